// File: verilog/field_move_regs.svh
// Register offsets, field positions and fixed values of the field move datapath
`ifndef FIELD_MOVE_REGS_SVH
`define FIELD_MOVE_REGS_SVH

// Register byte offsets
`define FM_OFF_CMD   8'h00
`define FM_OFF_IMM   8'h04
`define FM_OFF_SADDR 8'h08
`define FM_OFF_DADDR 8'h0C
`define FM_OFF_LIST  8'h10
`define FM_OFF_FCFG  8'h14
`define FM_OFF_STAT  8'h18
`define FM_OFF_RSEL  8'h1C
`define FM_OFF_RDAT  8'h20

// Command register fields
`define CMD_OP    3:0
`define CMD_SFILE 4
`define CMD_DFILE 5
`define CMD_SIDX  9:6
`define CMD_DIDX  13:10
`define CMD_SMEM  14
`define CMD_DMEM  15
`define CMD_FSEL  16
`define CMD_K     21:17
`define CMD_W     22

// Field configuration fields
`define FC_SIZE_A 4:0
`define FC_EXT_A  5
`define FC_SIZE_B 10:6
`define FC_EXT_B  11
`define FC_W      12

// Register window select, status bits
`define RS_W      5
`define ST_BUSY   0
`define ST_ERR    1

// Fixed values
`define BYTE_SIZE  6'd8
`define FULL_SIZE  6'd32
`define LW_BITS    7'd32
`define HSIZE_WORD 3'h2
`define LAST_REG   4'hF
`define ZERO32     32'h0000_0000
`define ONE32      32'h0000_0001

`endif

// File: verilog/field_move_pkg.sv
// Types shared by the field move datapath
`default_nettype none
package field_move_pkg;
  // Operation codes, in command encoding order
  typedef enum logic [3:0] {
    OP_MOVE_RR, OP_LOAD_SMALL_CONSTANT, OP_LOAD_IMMEDIATE16, OP_LOAD_IMMEDIATE32,
    OP_MOVE_LOW_HALF, OP_MOVE_HIGH_HALF, OP_MULTI_REGISTER_STORE,
    OP_MULTI_REGISTER_LOAD, OP_BYTE_MOVE, OP_FIELD_MOVE
  } op_t;

  // Sequencer states
  typedef enum logic [3:0] {
    S_IDLE, S_EXEC, S_SRD_LO, S_SRD_HI, S_DRD_LO, S_DWR_LO,
    S_DRD_HI, S_DWR_HI, S_MULTI, S_MWAIT
  } state_t;
endpackage
`default_nettype wire

// File: verilog/field_move_datapath.sv
// Move and field move execution datapath with AHB-Lite control and memory port
//
// The implementer's own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "field_move_regs.svh"

// Behaviour
// - Register move copies all 32 bits between any two registers.
// - Only the register move may take source and destination from different files.
// - Small constant load writes a zero-extended value 1 to 32.
// - Immediate load exists with 16-bit and 32-bit immediates.
// - Low-half move writes bits 15:0; high-half move writes bits 31:16.
// - Multi store writes, multi load reads, starting at the pointer register address.
// - Register list selects which registers move; they move in ascending register order.
// - Byte move is a field move of size 8, with memory operands.
// - Byte move has no register-to-register form.
// - A memory byte may start at any bit; address marks its LSB.
// - Loaded byte sits at bit 0, sign replicated through upper 24 bits.
// - Field width may be any value from 1 to 32 bits.
// - A memory field occupies consecutive bits upward from its bit address.
// - A register field is right-justified at bit 0.
// - Select 0 uses size/extension pair A, select 1 pair B; default 0.
// - Field into a register is sign- or zero-extended to 32 bits.
// - Register-to-memory splits address into word and offset; may straddle two words.
// - After memory-to-register move upper bits are all ones or all zeros.
// - Memory-to-memory move reads source field, writes destination, crossing word boundaries.
// - Register-direct source and destination share a file, except the full move.
// - Short immediate form carries 16 bits, long form carries 32 bits.
module field_move_datapath (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic [26:0]      mem_addr_o,
  output logic [31:0]      mem_wdata_o,
  input  wire logic        mem_ack_i,
  input  wire logic [31:0] mem_rdata_i
);
  import field_move_pkg::*;

  logic [31:0] gpr_ff [32];
  logic [22:0] cmd_ff;
  logic [31:0] imm_ff;
  logic [31:0] saddr_ff;
  logic [31:0] daddr_ff;
  logic [15:0] list_ff;
  logic [12:0] fcfg_ff;
  logic [5:0]  rsel_ff;
  logic        err_ff;
  logic        go_ff;
  logic        wr_pend_ff;
  logic        rd_pend_ff;
  logic [7:0]  addr_ff;
  logic        hreadyout_ff;
  logic [31:0] hrdata_ff;
  state_t      state_ff;
  logic [31:0] val_ff;
  logic [31:0] lo_ff;
  logic [26:0] ptr_ff;
  logic [3:0]  cnt_ff;
  logic [4:0]  nw_ff;
  logic        wb_en_ff;
  logic [4:0]  wb_idx_ff;
  logic [31:0] wb_data_ff;
  logic        mem_req_ff;
  logic        mem_we_ff;
  logic [26:0] mem_addr_ff;
  logic [31:0] mem_wdata_ff;

  logic        take;
  logic        busy;
  logic        cfg_wr;
  logic [31:0] rd_mux;
  op_t         op;
  logic        dfile;
  logic [4:0]  rs_x_idx;
  logic [4:0]  rs_idx;
  logic [4:0]  rd_idx;
  logic [31:0] rs_x;
  logic [31:0] rs_same;
  logic [31:0] rd_cur;
  logic        is_byte;
  logic [4:0]  size5;
  logic [5:0]  fsize;
  logic        fext;
  logic [31:0] fmask;
  logic [4:0]  s_off;
  logic [4:0]  d_off;
  logic        s_strad;
  logic        d_strad;
  logic [63:0] ins64;
  logic [63:0] msk64;

  assign hreadyout_o = hreadyout_ff;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = hrdata_ff;
  assign mem_req_o   = mem_req_ff;
  assign mem_we_o    = mem_we_ff;
  assign mem_addr_o  = mem_addr_ff;
  assign mem_wdata_o = mem_wdata_ff;

  // Bus transfer qualification and write gating
  assign take   = hsel_i & htrans_i[1] & hready_i;
  assign busy   = (state_ff != S_IDLE) | go_ff;
  assign cfg_wr = wr_pend_ff & ~busy;

  // Operand decode
  assign op       = op_t'(cmd_ff[`CMD_OP]);
  assign dfile    = cmd_ff[`CMD_DFILE];
  assign rs_x_idx = {cmd_ff[`CMD_SFILE], cmd_ff[`CMD_SIDX]};
  assign rs_idx   = {dfile, cmd_ff[`CMD_SIDX]};
  assign rd_idx   = {dfile, cmd_ff[`CMD_DIDX]};
  assign rs_x     = gpr_ff[rs_x_idx];
  assign rs_same  = gpr_ff[rs_idx];
  assign rd_cur   = gpr_ff[rd_idx];

  // Field size and extension selection
  assign is_byte = (op == OP_BYTE_MOVE);
  assign size5   = cmd_ff[`CMD_FSEL] ? fcfg_ff[`FC_SIZE_B] : fcfg_ff[`FC_SIZE_A];
  assign fsize   = is_byte ? `BYTE_SIZE :
                   (size5 == 5'h00) ? `FULL_SIZE : {1'b0, size5};
  assign fext    = is_byte | (cmd_ff[`CMD_FSEL] ? fcfg_ff[`FC_EXT_B] : fcfg_ff[`FC_EXT_A]);
  assign fmask   = (fsize == `FULL_SIZE) ? ~`ZERO32 : ((`ONE32 << fsize[4:0]) - `ONE32);

  // Bit address split into long word and offset
  assign s_off   = saddr_ff[4:0];
  assign d_off   = daddr_ff[4:0];
  assign s_strad = ({2'b00, s_off} + {1'b0, fsize}) > `LW_BITS;
  assign d_strad = ({2'b00, d_off} + {1'b0, fsize}) > `LW_BITS;

  // Insert data and mask positioned across two long words
  assign ins64 = {`ZERO32, val_ff & fmask} << d_off;
  assign msk64 = {`ZERO32, fmask} << d_off;

  // Field pulled from a long word pair, right-justified and extended
  function automatic logic [31:0] extract(input logic [63:0] d, input logic [4:0] off);
    logic [63:0] sh;
    logic [31:0] m;
    logic [4:0]  top;
    sh  = d >> off;
    m   = sh[31:0] & fmask;
    top = 5'(fsize - 6'd1);
    extract = (fext & m[top]) ? (m | ~fmask) : m;
  endfunction

  // Register read mux for the bus
  always_comb begin
    rd_mux = `ZERO32;
    unique case (addr_ff)
      `FM_OFF_CMD:   rd_mux = {9'h000, cmd_ff};
      `FM_OFF_IMM:   rd_mux = imm_ff;
      `FM_OFF_SADDR: rd_mux = saddr_ff;
      `FM_OFF_DADDR: rd_mux = daddr_ff;
      `FM_OFF_LIST:  rd_mux = {16'h0000, list_ff};
      `FM_OFF_FCFG:  rd_mux = {19'h00000, fcfg_ff};
      `FM_OFF_STAT:  rd_mux = {30'h0000_0000, err_ff, busy};
      `FM_OFF_RSEL:  rd_mux = {26'h000_0000, rsel_ff};
      `FM_OFF_RDAT:  rd_mux = gpr_ff[rsel_ff[4:0]];
      default:       rd_mux = `ZERO32;
    endcase
  end

  // AHB-Lite slave: writes take no wait, reads one wait state
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wr_pend_ff   <= 1'b0;
      rd_pend_ff   <= 1'b0;
      addr_ff      <= 8'h00;
      hreadyout_ff <= 1'b1;
      hrdata_ff    <= `ZERO32;
    end else if (ce_i) begin
      wr_pend_ff   <= take & hwrite_i & (hsize_i == `HSIZE_WORD);
      rd_pend_ff   <= take & ~hwrite_i;
      hreadyout_ff <= ~(take & ~hwrite_i);
      if (take) begin
        addr_ff <= haddr_i[7:0];
      end
      if (rd_pend_ff) begin
        hrdata_ff <= rd_mux;
      end
    end
  end

  // Control registers, frozen while an operation runs
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cmd_ff   <= 23'h000000;
      imm_ff   <= `ZERO32;
      saddr_ff <= `ZERO32;
      daddr_ff <= `ZERO32;
      list_ff  <= 16'h0000;
      fcfg_ff  <= 13'h0000;
      rsel_ff  <= 6'h00;
      go_ff    <= 1'b0;
    end else if (ce_i) begin
      go_ff <= cfg_wr & (addr_ff == `FM_OFF_CMD);
      if (cfg_wr) begin
        unique case (addr_ff)
          `FM_OFF_CMD:   cmd_ff   <= hwdata_i[`CMD_W:0];
          `FM_OFF_IMM:   imm_ff   <= hwdata_i;
          `FM_OFF_SADDR: saddr_ff <= hwdata_i;
          `FM_OFF_DADDR: daddr_ff <= hwdata_i;
          `FM_OFF_LIST:  list_ff  <= hwdata_i[15:0];
          `FM_OFF_FCFG:  fcfg_ff  <= hwdata_i[`FC_W:0];
          `FM_OFF_RSEL:  rsel_ff  <= hwdata_i[`RS_W:0];
          default: ;
        endcase
      end
    end
  end

  // General-purpose register files A (0..15) and B (16..31)
  always_ff @(posedge core_clk_i) begin
    if (ce_i) begin
      if (wb_en_ff) begin
        gpr_ff[wb_idx_ff] <= wb_data_ff;
      end else if (cfg_wr & (addr_ff == `FM_OFF_RDAT)) begin
        gpr_ff[rsel_ff[4:0]] <= hwdata_i;
      end
    end
  end

  // Sequencer, register write-back and memory port
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_ff     <= S_IDLE;
      err_ff       <= 1'b0;
      val_ff       <= `ZERO32;
      lo_ff        <= `ZERO32;
      ptr_ff       <= 27'h0000000;
      cnt_ff       <= 4'h0;
      nw_ff        <= 5'h00;
      wb_en_ff     <= 1'b0;
      wb_idx_ff    <= 5'h00;
      wb_data_ff   <= `ZERO32;
      mem_req_ff   <= 1'b0;
      mem_we_ff    <= 1'b0;
      mem_addr_ff  <= 27'h0000000;
      mem_wdata_ff <= `ZERO32;
    end else if (ce_i) begin
      wb_en_ff <= 1'b0;
      if (mem_ack_i) begin
        mem_req_ff <= 1'b0;
      end
      unique case (state_ff)
        S_IDLE: begin
          if (go_ff) begin
            err_ff   <= 1'b0;
            state_ff <= S_EXEC;
          end
        end
        S_EXEC: begin
          state_ff <= S_IDLE;
          unique case (op)
            OP_MOVE_RR: begin
              wb(rd_idx, rs_x);
            end
            OP_LOAD_SMALL_CONSTANT: begin
              wb(rd_idx, {26'h0, cmd_ff[`CMD_K] == 5'h00, cmd_ff[`CMD_K]});
            end
            OP_LOAD_IMMEDIATE16: begin
              wb(rd_idx, {{16{imm_ff[15]}}, imm_ff[15:0]});
            end
            OP_LOAD_IMMEDIATE32: begin
              wb(rd_idx, imm_ff);
            end
            OP_MOVE_LOW_HALF: begin
              wb(rd_idx, {rd_cur[31:16], rs_same[15:0]});
            end
            OP_MOVE_HIGH_HALF: begin
              wb(rd_idx, {rs_same[31:16], rd_cur[15:0]});
            end
            OP_MULTI_REGISTER_STORE, OP_MULTI_REGISTER_LOAD: begin
              ptr_ff   <= rs_same[31:5];
              cnt_ff   <= 4'h0;
              nw_ff    <= 5'h00;
              state_ff <= S_MULTI;
            end
            OP_BYTE_MOVE, OP_FIELD_MOVE: begin
              if (is_byte & ~cmd_ff[`CMD_SMEM] & ~cmd_ff[`CMD_DMEM]) begin
                err_ff <= 1'b1;
              end else if (cmd_ff[`CMD_SMEM]) begin
                issue(1'b0, saddr_ff[31:5], `ZERO32);
                state_ff <= S_SRD_LO;
              end else begin
                finish_src(rs_same);
              end
            end
            default: begin
              err_ff <= 1'b1;
            end
          endcase
        end
        S_SRD_LO: begin
          if (mem_ack_i) begin
            lo_ff <= mem_rdata_i;
            if (s_strad) begin
              issue(1'b0, saddr_ff[31:5] + 27'h1, `ZERO32);
              state_ff <= S_SRD_HI;
            end else begin
              finish_src(extract({`ZERO32, mem_rdata_i}, s_off));
            end
          end
        end
        S_SRD_HI: begin
          if (mem_ack_i) begin
            finish_src(extract({mem_rdata_i, lo_ff}, s_off));
          end
        end
        S_DRD_LO: begin
          if (mem_ack_i) begin
            issue(1'b1, daddr_ff[31:5], (mem_rdata_i & ~msk64[31:0]) | ins64[31:0]);
            state_ff <= S_DWR_LO;
          end
        end
        S_DWR_LO: begin
          if (mem_ack_i) begin
            if (d_strad) begin
              issue(1'b0, daddr_ff[31:5] + 27'h1, `ZERO32);
              state_ff <= S_DRD_HI;
            end else begin
              state_ff <= S_IDLE;
            end
          end
        end
        S_DRD_HI: begin
          if (mem_ack_i) begin
            issue(1'b1, daddr_ff[31:5] + 27'h1, (mem_rdata_i & ~msk64[63:32]) | ins64[63:32]);
            state_ff <= S_DWR_HI;
          end
        end
        S_DWR_HI: begin
          if (mem_ack_i) begin
            state_ff <= S_IDLE;
          end
        end
        S_MULTI: begin
          if (list_ff[cnt_ff]) begin
            issue(op == OP_MULTI_REGISTER_STORE, ptr_ff + {22'h0, nw_ff}, gpr_ff[{dfile, cnt_ff}]);
            state_ff <= S_MWAIT;
          end else if (cnt_ff == `LAST_REG) begin
            state_ff <= S_IDLE;
          end else begin
            cnt_ff <= cnt_ff + 4'h1;
          end
        end
        S_MWAIT: begin
          if (mem_ack_i) begin
            if (op == OP_MULTI_REGISTER_LOAD) begin
              wb({dfile, cnt_ff}, mem_rdata_i);
            end
            nw_ff <= nw_ff + 5'h01;
            if (cnt_ff == `LAST_REG) begin
              state_ff <= S_IDLE;
            end else begin
              cnt_ff   <= cnt_ff + 4'h1;
              state_ff <= S_MULTI;
            end
          end
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

  // Queue a register write-back for the next edge
  task automatic wb(input logic [4:0] idx, input logic [31:0] data);
    wb_en_ff   <= 1'b1;
    wb_idx_ff  <= idx;
    wb_data_ff <= data;
  endtask

  // Start one long-word memory access
  task automatic issue(input logic we, input logic [26:0] a, input logic [31:0] d);
    mem_req_ff   <= 1'b1;
    mem_we_ff    <= we;
    mem_addr_ff  <= a;
    mem_wdata_ff <= d;
  endtask

  // Source field known: insert into memory or extend into a register
  task automatic finish_src(input logic [31:0] v);
    if (cmd_ff[`CMD_DMEM]) begin
      val_ff   <= v;
      issue(1'b0, daddr_ff[31:5], `ZERO32);
      state_ff <= S_DRD_LO;
    end else begin
      wb(rd_idx, extract({`ZERO32, v}, 5'h00));
      state_ff <= S_IDLE;
    end
  endtask

endmodule // field_move_datapath
`default_nettype wire

// File: verification/field_move_properties.sv
// Port-level checker for the field move datapath, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module field_move_properties (
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire logic        ce_i,
  input wire logic        hsel_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic [31:0] hrdata_o,
  input wire logic        mem_req_o,
  input wire logic        mem_we_o,
  input wire logic [26:0] mem_addr_o,
  input wire logic [31:0] mem_wdata_o,
  input wire logic        mem_ack_i
);
  wire logic take;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Address phase accepted by the slave
  assign take = ce_i && hsel_i && htrans_i[1] && hready_i;
  a_resp_okay: assert property (hresp_o == 1'b0)
    else $error("response not okay");
  a_read_wait_one: assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");
  a_write_no_wait: assert property (take && hwrite_i |=> hreadyout_o)
    else $error("write stalled");
  a_ready_low_once: assert property (!hreadyout_o |=> hreadyout_o)
    else $error("ready low too long");
  a_mem_req_holds: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
    else $error("memory request dropped or moved");
  a_wdata_holds: assert property (mem_req_o && mem_we_o && !mem_ack_i |=> $stable(mem_wdata_o))
    else $error("write data changed early");
  a_rdata_only_read: assert property (!$stable(hrdata_o) |-> $past(hreadyout_o) == 1'b0)
    else $error("read data changed outside a read");
  a_reset_idle: assert property (disable iff (1'b0) !rst_n_i && ce_i |=> !mem_req_o && hreadyout_o && hrdata_o == 32'h0)
    else $error("reset state wrong");
endmodule // field_move_properties
bind field_move_datapath field_move_properties i_field_move_properties (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .hrdata_o(hrdata_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
  .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i));
`default_nettype wire

// File: verification/field_mem_model.sv
// Long-word memory answering the datapath memory port with a set latency
`timescale 1ns/1ps
`default_nettype none
module field_mem_model (
  input  wire logic        core_clk_i,
  input  wire logic [3:0]  lat_i,
  input  wire logic        mem_req_i,
  input  wire logic        mem_we_i,
  input  wire logic [26:0] mem_addr_i,
  input  wire logic [31:0] mem_wdata_i,
  output logic             mem_ack_o,
  output logic [31:0]      mem_rdata_o
);
  logic [31:0] mem [0:63];
  logic [3:0]  wait_cnt;
  logic [31:0] noise;
  initial begin
    mem_ack_o = 1'b0;
    wait_cnt = 4'h0;
    noise = 32'h0F0F_A5A5;
    foreach (mem[i]) mem[i] = 32'h0;
  end
  // One-cycle ack after lat_i waits; each access earns its own wait
  always @(posedge core_clk_i) begin
    noise <= ~noise ^ {noise[30:0], noise[31]};
    mem_ack_o <= 1'b0;
    if (mem_req_i && !mem_ack_o) begin
      if (wait_cnt >= lat_i) begin
        mem_ack_o <= 1'b1;
        wait_cnt <= 4'h0;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
    if (mem_ack_o && mem_req_i && mem_we_i) mem[mem_addr_i[5:0]] <= mem_wdata_i; // Word index only
  end
  // Data valid in the ack cycle only, a changing pattern otherwise
  assign mem_rdata_o = (mem_ack_o && !mem_we_i) ? mem[mem_addr_i[5:0]] : noise;
endmodule // field_mem_model
`default_nettype wire

// File: verification/field_move_datapath_test.sv
// Self-checking bench for the field move datapath
`timescale 1ns/1ps
`default_nettype none
module field_move_datapath_test;
  typedef struct packed {
    logic [3:0]  op;
    logic        sf;
    logic [3:0]  si;
    logic        df;
    logic [3:0]  di;
    logic [4:0]  k;
    logic        fs;
    logic [31:0] imm;
    logic [31:0] sv;
    logic [31:0] dv;
    logic [31:0] ev;
  } row_t;
  logic        core_clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        ce = 1'h1;
  logic        hsel = 1'h1;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [3:0]  lat = 4'h0;
  logic        hreadyout, hresp, mem_req, mem_we, mem_ack;
  logic [31:0] hrdata, mem_wdata, mem_rdata, v;
  logic [26:0] mem_addr;
  int          err_total = 0;
  int          checks_done = 0;
  // Register ops: inputs beside the expected destination value
  row_t rows [0:8] = '{
    '{4'h0,1'h0,4'h3,1'h1,4'h5,5'h00,1'h0,32'h0,32'h89ABCDEF,32'h0,32'h89ABCDEF},
    '{4'h1,1'h0,4'h1,1'h0,4'h2,5'h00,1'h0,32'h0,32'h0,32'hFFFFFFFF,32'h00000020},
    '{4'h1,1'h0,4'h1,1'h0,4'h2,5'h01,1'h0,32'h0,32'h0,32'hFFFFFFFF,32'h00000001},
    '{4'h2,1'h1,4'h1,1'h1,4'h2,5'h00,1'h0,32'h00008001,32'h0,32'h0,32'hFFFF8001},
    '{4'h3,1'h1,4'h1,1'h1,4'h2,5'h00,1'h0,32'h87654321,32'h0,32'h0,32'h87654321},
    '{4'h4,1'h1,4'h4,1'h1,4'h6,5'h00,1'h0,32'h0,32'hAAAA1234,32'h55559999,32'h55551234},
    '{4'h5,1'h1,4'h4,1'h1,4'h6,5'h00,1'h0,32'h0,32'h1234AAAA,32'h55559999,32'h12349999},
    '{4'h9,1'h0,4'h4,1'h0,4'h6,5'h00,1'h0,32'h0,32'h00000013,32'h0,32'hFFFFFFF3},
    '{4'h9,1'h0,4'h4,1'h0,4'h6,5'h00,1'h1,32'h0,32'h00000013,32'hFFFFFFFF,32'h00000013}};
  assign hready = hreadyout;
  wire logic hready;
  always #25 core_clk = ~core_clk;
  field_move_datapath i_field_move_datapath (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .ce_i(ce), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hreadyout),
    .hresp_o(hresp), .hrdata_o(hrdata), .mem_req_o(mem_req), .mem_we_o(mem_we), .mem_addr_o(mem_addr),
    .mem_wdata_o(mem_wdata), .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata));
  field_mem_model i_field_mem_model (
    .core_clk_i(core_clk), .lat_i(lat), .mem_req_i(mem_req), .mem_we_i(mem_we), .mem_addr_i(mem_addr),
    .mem_wdata_i(mem_wdata), .mem_ack_o(mem_ack), .mem_rdata_o(mem_rdata));
  task automatic results();
    $display("Errors %0d of %0d checks", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge core_clk);
    while (hready !== 1'h1 && n < 50) begin
      n++;
      @(posedge core_clk);
    end
    if (n >= 50) begin
      err_total++;
      $display("CHECK FAILED %0t bus hang", $time);
      results();
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= 1'h1;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= 1'h0;
    wait_ready();
    htrans <= 2'h0;
    wait_ready();
    d = hrdata;
  endtask
  function automatic logic [31:0] mk(input logic [3:0] op, input logic sf, df, input logic [3:0] si, di,
                                     input logic sm, dm, fs, input logic [4:0] k);
    return {10'h0, k, fs, dm, sm, di, si, df, sf, op};
  endfunction
  // Issue a command, then poll busy with a bound
  task automatic run_cmd(input logic [31:0] c);
    logic [31:0] st;
    int n;
    bus_wr(8'h00, c);
    bus_rd(8'h18, st);
    n = 0;
    do begin
      bus_rd(8'h18, st);
      n++;
    end while (st[0] !== 1'h0 && n < 100);
    if (n >= 100) begin
      err_total++;
      $display("CHECK FAILED %0t busy stuck", $time);
      results();
    end
  endtask
  task automatic set_reg(input logic f, input logic [3:0] i, input logic [31:0] d);
    bus_wr(8'h1C, {27'h0, f, i});
    bus_wr(8'h20, d);
  endtask
  task automatic get_reg(input logic f, input logic [3:0] i, output logic [31:0] d);
    bus_wr(8'h1C, {27'h0, f, i});
    bus_rd(8'h20, d);
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'h1;
    @(posedge core_clk);
    bus_rd(8'h18, v);
    chk(v, 32'h0);
    bus_rd(8'h40, v);
    chk(v, 32'h0);
    bus_wr(8'h14, 32'h0000_0165);
    foreach (rows[i]) begin
      set_reg(rows[i].sf, rows[i].si, rows[i].sv);
      set_reg(rows[i].df, rows[i].di, rows[i].dv);
      bus_wr(8'h04, rows[i].imm);
      run_cmd(mk(rows[i].op, rows[i].sf, rows[i].df, rows[i].si, rows[i].di, 1'h0, 1'h0, rows[i].fs, rows[i].k));
      get_reg(rows[i].df, rows[i].di, v);
      chk(v, rows[i].ev);
    end
    // Slow memory, 12-bit signed fields across word boundaries
    lat <= 4'h3;
    bus_wr(8'h14, 32'h0000_002C);
    i_field_mem_model.mem[2] = 32'hA000_0000;
    i_field_mem_model.mem[3] = 32'h0000_00C5;
    bus_wr(8'h08, 32'd92);
    run_cmd(mk(4'h9, 1'h0, 1'h0, 4'h0, 4'h7, 1'h1, 1'h0, 1'h0, 5'h0));
    get_reg(1'h0, 4'h7, v);
    chk(v, 32'hFFFF_FC5A);
    i_field_mem_model.mem[4] = 32'h1234_5678;
    i_field_mem_model.mem[5] = 32'hFFFF_FFFF;
    set_reg(1'h0, 4'h8, 32'h0000_0ABC);
    bus_wr(8'h0C, 32'd154);
    run_cmd(mk(4'h9, 1'h0, 1'h0, 4'h8, 4'h0, 1'h0, 1'h1, 1'h0, 5'h0));
    chk(i_field_mem_model.mem[4], 32'hF234_5678);
    chk(i_field_mem_model.mem[5], 32'hFFFF_FFEA);
    // Byte moves at unaligned bit addresses, then the rejected register-to-register form
    i_field_mem_model.mem[8] = 32'h0000_0F50;
    bus_wr(8'h08, 32'd259);
    bus_wr(8'h0C, 32'd318);
    run_cmd(mk(4'h8, 1'h0, 1'h0, 4'h0, 4'h0, 1'h1, 1'h1, 1'h0, 5'h0));
    chk(i_field_mem_model.mem[9], 32'h8000_0000);
    chk(i_field_mem_model.mem[10], 32'h0000_003A);
    run_cmd(mk(4'h8, 1'h0, 1'h0, 4'h0, 4'h9, 1'h1, 1'h0, 1'h0, 5'h0));
    get_reg(1'h0, 4'h9, v);
    chk(v, 32'hFFFF_FFEA);
    set_reg(1'h0, 4'hA, 32'h0000_0055);
    set_reg(1'h0, 4'hB, 32'h0000_0077);
    run_cmd(mk(4'h8, 1'h0, 1'h0, 4'hA, 4'hB, 1'h0, 1'h0, 1'h0, 5'h0));
    bus_rd(8'h18, v);
    chk(v, 32'h0000_0002);
    get_reg(1'h0, 4'hB, v);
    chk(v, 32'h0000_0077);
    // Multi store then load, pointer in the same file as the list
    set_reg(1'h0, 4'h0, 32'd512);
    set_reg(1'h0, 4'h1, 32'h1111_1111);
    set_reg(1'h0, 4'h3, 32'h3333_3333);
    bus_wr(8'h10, 32'h0000_000A);
    run_cmd(mk(4'h6, 1'h0, 1'h0, 4'h0, 4'h0, 1'h0, 1'h0, 1'h0, 5'h0));
    chk(i_field_mem_model.mem[16], 32'h1111_1111);
    chk(i_field_mem_model.mem[17], 32'h3333_3333);
    i_field_mem_model.mem[16] = 32'h5A5A_0001;
    i_field_mem_model.mem[17] = 32'h5A5A_0003;
    run_cmd(mk(4'h7, 1'h0, 1'h0, 4'h0, 4'h0, 1'h0, 1'h0, 1'h0, 5'h0));
    get_reg(1'h0, 4'h1, v);
    chk(v, 32'h5A5A_0001);
    get_reg(1'h0, 4'h3, v);
    chk(v, 32'h5A5A_0003);
    // Second reset with the datapath idle, status reads zero afterwards
    rst_n <= 1'h0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'h1;
    @(posedge core_clk);
    bus_rd(8'h18, v);
    chk(v, 32'h0);
    results();
  end
endmodule // field_move_datapath_test
`default_nettype wire
